/* rtl/tli_table_lookup_interpolate.v */
// table lookup and linear interpolation execution datapath
`timescale 1ns/1ps
`include "tli_defs.vh"
module tli_table_lookup_interpolate #(
  parameter ADDR_W = 32
) (
  input  wire              core_clk,
  input  wire              resetn,
  input  wire              start,
  input  wire              isSigned,
  input  wire              isRounded,
  input  wire [1:0]        opSize,
  input  wire              usePair,
  input  wire [31:0]       independentVariable,
  input  wire [31:0]       surfaceFraction,
  input  wire [31:0]       pairFirst,
  input  wire [31:0]       pairSecond,
  input  wire [ADDR_W-1:0] tableBase,
  input  wire              memAck,
  input  wire [31:0]       memData,
  output reg               memReq,
  output reg  [ADDR_W-1:0] memAddr,
  output reg  [1:0]        memSize,
  output reg               busy,
  output reg               done,
  output reg  [31:0]       result
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // extend a sized entry to 33 bits
  function [32:0] extendEntry;
    input [31:0] v;
    input [1:0]  sz;
    input        sgn;
    begin
      case (sz)
        `TLI_SIZE_BYTE: extendEntry = {{25{sgn & v[7]}}, v[7:0]};
        `TLI_SIZE_WORD: extendEntry = {{17{sgn & v[15]}}, v[15:0]};
        default:        extendEntry = {sgn & v[31], v};
      endcase
    end
  endfunction

  // byte stride of one entry
  function [ADDR_W-1:0] entryBytes;
    input [1:0] sz;
    begin
      case (sz)
        `TLI_SIZE_BYTE: entryBytes = {{(ADDR_W-1){1'b0}}, 1'b1};
        `TLI_SIZE_WORD: entryBytes = {{(ADDR_W-2){1'b0}}, 2'h2};
        default:        entryBytes = {{(ADDR_W-3){1'b0}}, 3'h4};
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [32:0] entryLo;
  reg  [32:0] entryHi;
  reg  [7:0]  frac;
  reg         sgnR;
  reg         rndR;
  reg  [1:0]  sizeR;

  // ------------------------------------------------------------
  // state encoding
  // ------------------------------------------------------------
  localparam [1:0] ST_IDLE   = `TLI_ST_IDLE;
  localparam [1:0] ST_FETCH0 = `TLI_ST_FETCH0;
  localparam [1:0] ST_FETCH1 = `TLI_ST_FETCH1;
  localparam [1:0] ST_CALC   = `TLI_ST_CALC;

  // start is only taken while idle
  wire        takeStart = (state == ST_IDLE) & start;

  wire [7:0]  entryOffset = independentVariable[`TLI_OFS_HI:`TLI_OFS_LO];
  wire [7:0]  entryFrac   = independentVariable[`TLI_FRAC_HI:`TLI_FRAC_LO];
  wire [ADDR_W-1:0] offsetBytes = {{(ADDR_W-8){1'b0}}, entryOffset} * entryBytes(opSize);

  // ------------------------------------------------------------
  // arithmetic
  // ------------------------------------------------------------
  wire signed [33:0] diff    = $signed({entryHi[32], entryHi}) - $signed({entryLo[32], entryLo});
  wire signed [42:0] prod    = diff * $signed({1'b0, frac});
  wire signed [42:0] scaled  = $signed({{2{entryLo[32]}}, entryLo, 8'h00}) + prod;
  wire [7:0]         fracBits = scaled[7:0];
  wire [34:0]        intPart  = scaled[42:8];
  wire               roundUp  = fracBits[7] & ((|fracBits[6:0]) | intPart[0]);
  wire [34:0]        rounded  = intPart + {34'h0, roundUp};
  wire [31:0]        rawOut   = rndR ? rounded[31:0] : scaled[31:0];

  reg  [31:0] sizedOut;
  always @* begin
    case (sizeR)
      `TLI_SIZE_BYTE: sizedOut = {24'h0, rawOut[7:0]};
      `TLI_SIZE_WORD: sizedOut = {16'h0, rawOut[15:0]};
      default:        sizedOut = rawOut;
    endcase
  end

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = usePair ? ST_CALC : ST_FETCH0;
        end
      end
      ST_FETCH0: begin
        if (memAck) begin
          next_state = ST_FETCH1;
        end
      end
      ST_FETCH1: begin
        if (memAck) begin
          next_state = ST_CALC;
        end
      end
      ST_CALC: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // control
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      done  <= (state == ST_CALC);
      if (takeStart) begin
        busy <= 1'b1;
      end else if (state == ST_CALC) begin
        busy <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // operand capture
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      frac  <= 8'h00;
      sgnR  <= 1'b0;
      rndR  <= 1'b0;
      sizeR <= `TLI_SIZE_BYTE;
    end else if (takeStart) begin
      sgnR  <= isSigned;
      rndR  <= isRounded;
      sizeR <= opSize;
      if (usePair) begin
        frac <= surfaceFraction[`TLI_FRAC_HI:`TLI_FRAC_LO];
      end else begin
        frac <= entryFrac;
      end
    end
  end

  // ------------------------------------------------------------
  // endpoints
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      entryLo <= 33'h0;
      entryHi <= 33'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start && usePair) begin
            entryLo <= extendEntry(pairFirst, opSize, isSigned);
            entryHi <= extendEntry(pairSecond, opSize, isSigned);
          end
        end
        ST_FETCH0: begin
          if (memAck) begin
            entryLo <= extendEntry(memData, sizeR, sgnR);
          end
        end
        ST_FETCH1: begin
          if (memAck) begin
            entryHi <= extendEntry(memData, sizeR, sgnR);
          end
        end
        default: entryLo <= entryLo;
      endcase
    end
  end

  // ------------------------------------------------------------
  // table reads
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      memReq  <= 1'b0;
      memAddr <= {ADDR_W{1'b0}};
      memSize <= `TLI_SIZE_BYTE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start && !usePair) begin
            memReq  <= 1'b1;
            memAddr <= tableBase + offsetBytes;
            memSize <= opSize;
          end
        end
        ST_FETCH0: begin
          if (memAck) begin
            memAddr <= memAddr + entryBytes(sizeR);
          end
        end
        ST_FETCH1: begin
          if (memAck) begin
            memReq <= 1'b0;
          end
        end
        default: memReq <= 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // result
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      result <= 32'h0;
    end else if (state == ST_CALC) begin
      result <= sizedOut;
    end
  end

endmodule

/* rtl/tli_defs.vh */
// constants for the table lookup and interpolate datapath
`ifndef TLI_DEFS_VH
`define TLI_DEFS_VH
`define TLI_SIZE_BYTE 2'h0
`define TLI_SIZE_WORD 2'h1
`define TLI_SIZE_LONG 2'h2
`define TLI_OFS_HI    15
`define TLI_OFS_LO    8
`define TLI_FRAC_HI   7
`define TLI_FRAC_LO   0
`define TLI_FRAC_W    8
`define TLI_ST_IDLE   2'h0
`define TLI_ST_FETCH0 2'h1
`define TLI_ST_FETCH1 2'h2
`define TLI_ST_CALC   2'h3
`endif

/* test/tli_checker.sv */
// port checks for the lookup datapath
`timescale 1ns/1ps
module tli_checker #(parameter ADDR_W = 32) (
  input logic core_clk, resetn, start, usePair, memAck, memReq, busy, done,
  input logic [1:0] opSize, memSize,
  input logic [31:0] independentVariable, result,
  input logic [ADDR_W-1:0] tableBase, memAddr);
  logic take;
  logic [2:0] nb;
  logic [ADDR_W-1:0] fa;
  assign take = start && !busy;
  assign nb = opSize == 2'h0 ? 3'h1 : opSize == 2'h1 ? 3'h2 : 3'h4;
  assign fa = tableBase + independentVariable[15:8] * nb;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence pairWalk; busy && !done ##1 done && !busy; endsequence
  pair_walk_a: assert property (take && usePair |=> pairWalk) else $error("pair");
  first_entry_a: assert property (take && !usePair |=> memReq && memAddr == $past(fa))
    else $error("first");
  next_entry_a: assert property (memReq && memAck && $past(take) |=>
    memAddr == $past(memAddr) + $past(nb, 2)) else $error("next");
  fetch_end_a: assert property ($fell(memReq) |=> done && !busy) else $error("end");
  req_busy_a: assert property (memReq |-> busy && !done) else $error("req");
  done_pulse_a: assert property (done |=> !done) else $error("pulse");
  result_hold_a: assert property (!done |-> $stable(result)) else $error("hold");
  busy_cause_a: assert property ($rose(busy) |-> $past(start)) else $error("busy");
  size_req_a: assert property (take && !usePair |=> memSize == $past(opSize))
    else $error("size");
endmodule
bind tli_table_lookup_interpolate tli_checker #(.ADDR_W(ADDR_W)) chk (.*);

/* test/testbench.sv */
// bench for the lookup datapath
`timescale 1ns/1ps
module testbench;
  reg core_clk = 0, resetn = 0, start = 0, isSigned = 0, isRounded = 0, usePair = 0;
  reg memAck = 0, ak;
  reg [1:0] opSize = 0;
  reg [31:0] independentVariable = 0, surfaceFraction = 0, pairFirst = 0, pairSecond = 0;
  reg [31:0] tableBase = 0, memData = 0, ad, mk, tbl [0:2047], expQ [$];
  wire memReq, busy, done;
  wire [1:0] memSize;
  wire [31:0] memAddr, result;
  integer seed = 83, n_errors = 0, n_tests = 0, cycles = 0, i, sh;
  tli_table_lookup_interpolate uut (.*);
  always #2.5 core_clk = ~core_clk;
  function automatic longint ext(input [31:0] d);
    ext = isSigned ? longint'({d, 32'h0} << sh) >>> (sh + 32) : longint'(d & mk);
  endfunction
  function automatic [31:0] interp(input longint lo, hi, input [7:0] f);
    longint v;
    v = lo * 256 + f * (hi - lo);
    if (isRounded) v = (v + 127 + v[8]) >>> 8;
    interp = v[31:0] & mk;
  endfunction
  task check(input [31:0] e, g);
    n_tests++;
    if (g !== e) n_errors++;
    if (g !== e) $display("[FAIL] %0t exp %h got %h", $time, e, g);
  endtask
  task finish_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk) if (++cycles == 9000) begin
    n_errors++;
    finish_test;
  end
  always @(negedge core_clk) begin
    ak = memReq & $random(seed);
    memAck <= ak;
    memData <= ak ? tbl[memAddr[10:0]] : $random(seed);
    if (done === 1'b1) check(expQ.pop_front(), result);
  end
  initial begin
    for (i = 0; i < 2048; i++) tbl[i] = $random(seed);
    repeat (10) @(negedge core_clk);
    resetn = 1;
    for (i = 0; i < 400; i++) begin
      while (busy !== 1'b0) begin
        start = 0;
        @(negedge core_clk);
      end
      {isSigned, isRounded, usePair, opSize} = $random(seed);
      if (i % 8 == 0) {isSigned, isRounded, usePair, opSize} = 5'h1d;
      independentVariable = $random(seed);
      surfaceFraction = $random(seed);
      pairFirst = $random(seed);
      pairSecond = $random(seed);
      tableBase = $random(seed);
      start = 1;
      sh = opSize == 0 ? 24 : opSize == 1 ? 16 : 0;
      mk = 32'hffffffff >> sh;
      ad = tableBase + independentVariable[15:8] * (4 - sh / 8);
      if (usePair) expQ.push_back(interp(ext(pairFirst), ext(pairSecond), surfaceFraction[7:0]));
      else expQ.push_back(interp(ext(tbl[ad[10:0]]), ext(tbl[11'(ad + 4 - sh / 8)]),
        independentVariable[7:0]));
      @(negedge core_clk);
      start = $random(seed);
      @(negedge core_clk);
    end
    start = 0;
    repeat (20) @(negedge core_clk);
    if (expQ.size() != 0) n_errors++;
    finish_test;
  end
endmodule
